// ---- abs_pos_pkg.sv ----
package abs_pos_pkg;

	// clock and timing figures
	localparam int unsigned CLK_KHZ        = 250000;
	localparam int unsigned REQ_WAIT_MS    = 100;
	localparam int unsigned SETTLE_MS      = 25;
	localparam int unsigned REQ_WAIT_CYC   = REQ_WAIT_MS * CLK_KHZ;
	localparam int unsigned SETTLE_CYC     = SETTLE_MS * CLK_KHZ;
	localparam int unsigned TIMER_W        = 32;

	// power-up check happens once synchronisers have settled
	localparam logic [3:0]  PU_CHECK_CYC   = 4'h8;

	// initial incremental pulse pacing: clocks per quadrature edge
	localparam logic [7:0]  PULSE_DIV      = 8'h04;

	// multiturn count limits
	localparam logic signed [15:0] MT_MAX  = 16'sh7fff;
	localparam logic signed [15:0] MT_MIN  = 16'sh8000;
	localparam logic signed [15:0] MT_ZERO = 16'sh0000;

	// serial frame layout
	localparam int unsigned FRAME_BYTES    = 8;
	localparam logic [2:0]  FRAME_LAST     = 3'h7;
	localparam logic [7:0]  FRAME_SYNC     = 8'h55;
	localparam logic [7:0]  FRAME_END      = 8'h0d;
	localparam int unsigned STAT_BATT_BIT  = 0;
	localparam int unsigned STAT_SETUP_BIT = 1;
	localparam int unsigned STAT_INCR_BIT  = 2;

	// buffer shape
	localparam int unsigned FIFO_WIDTH     = 8;
	localparam int unsigned FIFO_DEPTH     = 16;

	// encoder usage select encodings
	localparam logic        USAGE_ABSOLUTE = 1'b0;
	localparam logic        USAGE_INCREMENTAL = 1'b1;

	// transfer sequencer states
	typedef enum logic [7:0] {
		ST_PWRUP  = 8'h01,
		ST_IDLE   = 8'h02,
		ST_WAIT   = 8'h04,
		ST_SEND   = 8'h08,
		ST_DRAIN  = 8'h10,
		ST_PULSE  = 8'h20,
		ST_SETTLE = 8'h40,
		ST_RUN    = 8'h80
	} xfer_state_t;

endpackage

// ---- byte_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 16
) (
	input  wire logic             mclk_in,
	input  wire logic             srst_in,
	input  wire logic             in_valid_in,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  in_ready_out,
	output logic                  out_valid_out,
	output logic      [WIDTH-1:0] out_data_out,
	input  wire logic             out_ready_in
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic             push;
	logic             pop;

	// honest flags straight from the fill count
	assign in_ready_out  = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid_out = (cnt_q != '0);
	assign out_data_out  = mem_q[rd_q];
	assign push          = in_valid_in && in_ready_out;
	assign pop           = out_valid_out && out_ready_in;

	// storage, written by index
	always_ff @(posedge mclk_in)
	begin
		if (push)
		begin
			mem_q[wr_q] <= in_data_in;
		end
	end

	// pointers and fill count
	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (push)
			begin
				wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
			end
			if (pop)
			begin
				rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule
`default_nettype wire

// ---- frame_byte.sv ----
`timescale 1ns/1ps
`default_nettype none
module frame_byte
	import abs_pos_pkg::*;
(
	input  wire logic [2:0]         idx_in,
	input  wire logic signed [15:0] turns_in,
	input  wire logic [15:0]        pos_in,
	input  wire logic [7:0]         status_in,
	output logic [7:0]              byte_out
);
	// xor check over the payload bytes
	function automatic logic [7:0] frame_check(
		input logic [15:0] t,
		input logic [15:0] p,
		input logic [7:0]  s
	);
		frame_check = t[15:8] ^ t[7:0] ^ p[15:8] ^ p[7:0] ^ s;
	endfunction

	// fixed eight-byte layout, sync byte then multiturn count, big end first
	always_comb
	begin
		unique case (idx_in)
			3'h0: byte_out = FRAME_SYNC;
			3'h1: byte_out = turns_in[15:8];
			3'h2: byte_out = turns_in[7:0];
			3'h3: byte_out = pos_in[15:8];
			3'h4: byte_out = pos_in[7:0];
			3'h5: byte_out = status_in;
			3'h6: byte_out = frame_check(turns_in, pos_in, status_in);
			3'h7: byte_out = FRAME_END;
		endcase
	end
endmodule
`default_nettype wire

// ---- abs_position_handshake.sv ----
// Functional notes
// - Count spans +32767..-32768; forward past top wraps to -32768.
// - Reverse past -32768 wraps the count to +32767.
// - Request low at power-up; raising it asks for absolute data.
// - Request rise sends multiturn count, then initial incremental pulses.
// - Servo-on refused and baseblock shown until the transfer finishes.
// - Usage select picks absolute (default) or plain incremental operation.
// - Incremental operation ignores the request input and the battery.
// - Usage select change takes effect only after a power cycle.
// - Battery below about 2.7 V raises the battery-low alarm.
// - Battery checked only at power-up, never while running.
// - Battery alarm stays set until the next power cycle.
// - Lost backup with control power off demands a fresh encoder setup.
// - Multiturn position travels as eight serial bytes to the host.
// - About 25 ms after the last initial incremental pulse, normal pulse output begins.
`timescale 1ns/1ps
`default_nettype none
module abs_position_handshake
	import abs_pos_pkg::*;
#(
	parameter int unsigned REQ_WAIT = REQ_WAIT_CYC,
	parameter int unsigned SETTLE   = SETTLE_CYC
) (
	input  wire logic        mclk_in,
	input  wire logic        srst_in,
	input  wire logic        absolute_data_request_in,
	input  wire logic        encoder_usage_select_in,
	input  wire logic        battery_low_in,
	input  wire logic        backup_lost_in,
	input  wire logic        servo_on_req_in,
	input  wire logic        enc_a_in,
	input  wire logic        enc_b_in,
	input  wire logic [15:0] turns_preset_in,
	input  wire logic        rev_fwd_in,
	input  wire logic        rev_rev_in,
	input  wire logic [15:0] turn_pos_in,
	output logic [7:0]       ser_data_out,
	output logic             ser_valid_out,
	input  wire logic        ser_ready_in,
	output logic             pulse_a_out,
	output logic             pulse_b_out,
	output logic             servo_on_out,
	output logic             baseblock_out,
	output logic             battery_alarm_out,
	output logic             setup_needed_out,
	output logic             incremental_mode_out,
	output logic             xfer_done_out,
	output logic signed [15:0] turns_out
);

	////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic [1:0] req_s_q;
	logic [1:0] usage_s_q;
	logic [1:0] batt_s_q;
	logic [1:0] lost_s_q;
	logic [1:0] son_s_q;
	logic [1:0] enca_s_q;
	logic [1:0] encb_s_q;
	logic       req_d1_q;

	// two flops per pin; only the second stage is read below
	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			req_s_q   <= 2'h0;
			usage_s_q <= 2'h0;
			batt_s_q  <= 2'h0;
			lost_s_q  <= 2'h0;
			son_s_q   <= 2'h0;
			enca_s_q  <= 2'h0;
			encb_s_q  <= 2'h0;
			req_d1_q  <= 1'b0;
		end
		else
		begin
			req_s_q   <= {req_s_q[0], absolute_data_request_in};
			usage_s_q <= {usage_s_q[0], encoder_usage_select_in};
			batt_s_q  <= {batt_s_q[0], battery_low_in};
			lost_s_q  <= {lost_s_q[0], backup_lost_in};
			son_s_q   <= {son_s_q[0], servo_on_req_in};
			enca_s_q  <= {enca_s_q[0], enc_a_in};
			encb_s_q  <= {encb_s_q[0], enc_b_in};
			req_d1_q  <= req_s_q[1];
		end
	end

	logic req_rise;
	assign req_rise = req_s_q[1] && !req_d1_q;

	////////////////////////////////////////////////////////////////
	// power-up check

	logic [3:0] pu_cnt_q;
	logic       pu_check;
	logic       usage_q;
	logic       batt_alarm_q;
	logic       setup_q;

	assign pu_check = (pu_cnt_q == PU_CHECK_CYC - 4'h1);

	// counts once after reset, then parks; reset stands for power-up
	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			pu_cnt_q <= 4'h0;
		end
		else if (pu_cnt_q != PU_CHECK_CYC)
		begin
			pu_cnt_q <= pu_cnt_q + 4'h1;
		end
	end

	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			usage_q <= USAGE_ABSOLUTE;
		end
		else if (pu_check)
		begin
			usage_q <= usage_s_q[1];
		end
	end

	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			batt_alarm_q <= 1'b0;
		end
		else if (pu_check)
		begin
			batt_alarm_q <= batt_s_q[1] && (usage_s_q[1] == USAGE_ABSOLUTE);
		end
	end

	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			setup_q <= 1'b0;
		end
		else if (pu_check)
		begin
			setup_q <= lost_s_q[1] && (usage_s_q[1] == USAGE_ABSOLUTE);
		end
	end

	////////////////////////////////////////////////////////////////
	// multiturn revolution count

	logic signed [15:0] turns_q;

	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			turns_q <= MT_ZERO;
		end
		else if (pu_check)
		begin
			// a lost backup has no count worth loading
			turns_q <= lost_s_q[1] ? MT_ZERO : $signed(turns_preset_in);
		end
		else if (rev_fwd_in && !rev_rev_in)
		begin
			turns_q <= (turns_q == MT_MAX) ? MT_MIN : turns_q + 16'sh0001;
		end
		else if (rev_rev_in && !rev_fwd_in)
		begin
			turns_q <= (turns_q == MT_MIN) ? MT_MAX : turns_q - 16'sh0001;
		end
	end

	////////////////////////////////////////////////////////////////
	// transfer sequencer

	xfer_state_t        state_q;
	logic [TIMER_W-1:0] timer_q;
	logic [2:0]         idx_q;
	logic signed [15:0] snap_turns_q;
	logic [15:0]        snap_pos_q;
	logic [15:0]        pulse_left_q;
	logic [7:0]         div_q;
	logic [1:0]         phase_q;
	logic               timer_done;
	logic [7:0]         frame_byte_w;
	logic [7:0]         status_w;
	logic               fifo_in_ready;
	logic               fifo_out_valid;
	logic               push;
	logic               edge_tick;

	assign timer_done = (timer_q == '0);
	assign push       = (state_q == ST_SEND) && fifo_in_ready;
	assign edge_tick  = (div_q == '0);

	always_comb
	begin
		status_w                 = 8'h00;
		status_w[STAT_BATT_BIT]  = batt_alarm_q;
		status_w[STAT_SETUP_BIT] = setup_q;
		status_w[STAT_INCR_BIT]  = usage_q;
	end

	// state register; one concern, next state picked inline
	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			state_q <= ST_PWRUP;
		end
		else
		begin
			unique case (state_q)
				ST_PWRUP:
					if (pu_cnt_q == PU_CHECK_CYC)
					begin
						state_q <= (usage_q == USAGE_INCREMENTAL) ? ST_RUN
							: ST_IDLE;
					end
				ST_IDLE:
					if (req_rise)
					begin
						state_q <= ST_WAIT;
					end
				ST_WAIT:
					if (timer_done)
					begin
						state_q <= ST_SEND;
					end
				ST_SEND:
					if (push && idx_q == FRAME_LAST)
					begin
						state_q <= ST_DRAIN;
					end
				ST_DRAIN:
					if (!fifo_out_valid)
					begin
						state_q <= ST_PULSE;
					end
				ST_PULSE:
					if (pulse_left_q == '0)
					begin
						state_q <= ST_SETTLE;
					end
				ST_SETTLE:
					if (timer_done)
					begin
						state_q <= ST_RUN;
					end
				ST_RUN:
					// a fresh rise in absolute use repeats the transfer
					if (req_rise && usage_q == USAGE_ABSOLUTE)
					begin
						state_q <= ST_WAIT;
					end
			endcase
		end
	end

	// wait timer, loaded on entry to each timed phase
	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			timer_q <= '0;
		end
		else if ((state_q == ST_IDLE || state_q == ST_RUN) && req_rise)
		begin
			timer_q <= TIMER_W'(REQ_WAIT - 1);
		end
		else if (state_q == ST_PULSE && pulse_left_q == '0)
		begin
			timer_q <= TIMER_W'(SETTLE - 1);
		end
		else if (!timer_done)
		begin
			timer_q <= timer_q - 1'b1;
		end
	end

	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			snap_turns_q <= MT_ZERO;
			snap_pos_q   <= 16'h0000;
		end
		else if ((state_q == ST_IDLE || state_q == ST_RUN) && req_rise
			&& usage_q == USAGE_ABSOLUTE)
		begin
			snap_turns_q <= turns_q;
			snap_pos_q   <= turn_pos_in;
		end
	end

	// byte index walks the frame while the buffer accepts
	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			idx_q <= 3'h0;
		end
		else if (state_q == ST_WAIT)
		begin
			idx_q <= 3'h0;
		end
		else if (push)
		begin
			idx_q <= idx_q + 3'h1;
		end
	end

	////////////////////////////////////////////////////////////////
	// initial incremental pulses

	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			pulse_left_q <= 16'h0000;
			div_q        <= 8'h00;
			phase_q      <= 2'h0;
		end
		else if (state_q == ST_DRAIN)
		begin
			// one pulse per count of in-turn position
			pulse_left_q <= snap_pos_q;
			div_q        <= PULSE_DIV - 8'h01;
			phase_q      <= 2'h0;
		end
		else if (state_q == ST_PULSE && pulse_left_q != '0)
		begin
			div_q <= edge_tick ? PULSE_DIV - 8'h01 : div_q - 8'h01;
			if (edge_tick)
			begin
				// gray step keeps only one line moving per edge
				unique case (phase_q)
					2'h0: phase_q <= 2'h1;
					2'h1: phase_q <= 2'h3;
					2'h3: phase_q <= 2'h2;
					2'h2: phase_q <= 2'h0;
				endcase
				if (phase_q == 2'h2)
				begin
					pulse_left_q <= pulse_left_q - 16'h0001;
				end
			end
		end
	end

	// quadrature outputs: generated during the initial burst,
	// mirrored encoder lines in normal running
	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			pulse_a_out <= 1'b0;
			pulse_b_out <= 1'b0;
		end
		else if (state_q == ST_RUN)
		begin
			pulse_a_out <= enca_s_q[1];
			pulse_b_out <= encb_s_q[1];
		end
		else
		begin
			pulse_a_out <= phase_q[0];
			pulse_b_out <= phase_q[1];
		end
	end

	////////////////////////////////////////////////////////////////
	// servo interlock and status

	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			servo_on_out  <= 1'b0;
			baseblock_out <= 1'b1;
		end
		else
		begin
			servo_on_out  <= (state_q == ST_RUN) && son_s_q[1];
			baseblock_out <= !((state_q == ST_RUN) && son_s_q[1]);
		end
	end

	// status outputs, all registered
	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			battery_alarm_out    <= 1'b0;
			setup_needed_out     <= 1'b0;
			incremental_mode_out <= 1'b0;
			xfer_done_out        <= 1'b0;
			turns_out            <= MT_ZERO;
		end
		else
		begin
			battery_alarm_out    <= batt_alarm_q;
			setup_needed_out     <= setup_q;
			incremental_mode_out <= usage_q;
			xfer_done_out        <= (state_q == ST_RUN);
			turns_out            <= turns_q;
		end
	end

	////////////////////////////////////////////////////////////////
	// serial frame into the buffer

	frame_byte u_frame (
		.idx_in    (idx_q),
		.turns_in  (snap_turns_q),
		.pos_in    (snap_pos_q),
		.status_in (status_w),
		.byte_out  (frame_byte_w)
	);

	// a slow host stalls the sequencer in ST_DRAIN until the buffer empties
	byte_fifo #(
		.WIDTH (FIFO_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.mclk_in       (mclk_in),
		.srst_in       (srst_in),
		.in_valid_in   (state_q == ST_SEND),
		.in_data_in    (frame_byte_w),
		.in_ready_out  (fifo_in_ready),
		.out_valid_out (fifo_out_valid),
		.out_data_out  (ser_data_out),
		.out_ready_in  (ser_ready_in)
	);

	assign ser_valid_out = fifo_out_valid;

endmodule
`default_nettype wire

// ---- abs_pos_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module abs_pos_checker
	import abs_pos_pkg::*;
#(
	parameter int unsigned REQ_WAIT = 20,
	parameter int unsigned SETTLE   = 10
) (
	input wire logic               mclk_in,
	input wire logic               srst_in,
	input wire logic               rev_fwd_in,
	input wire logic               rev_rev_in,
	input wire logic [7:0]         ser_data_out,
	input wire logic               ser_valid_out,
	input wire logic               ser_ready_in,
	input wire logic               pulse_a_out,
	input wire logic               pulse_b_out,
	input wire logic               servo_on_out,
	input wire logic               baseblock_out,
	input wire logic               battery_alarm_out,
	input wire logic               setup_needed_out,
	input wire logic               incremental_mode_out,
	input wire logic               xfer_done_out,
	input wire logic signed [15:0] turns_out
);
	// cycles since reset, saturating; power-up sampling lands well inside 12
	logic [3:0] since_rst_q;
	always_ff @(posedge mclk_in)
		if (srst_in)
			since_rst_q <= 4'h0;
		else if (since_rst_q != 4'hf)
			since_rst_q <= since_rst_q + 4'h1;

	default clocking @(posedge mclk_in); endclocking
	default disable iff (srst_in);

	////////////////////////////////////////////////////////////////////////
	// lone pulses only, so the lagging count output can be compared safely
	property p_fwd_wrap;
		!rev_fwd_in && !rev_rev_in ##1 rev_fwd_in && !rev_rev_in ##1
		!rev_fwd_in && !rev_rev_in |=>
		turns_out == $past(turns_out, 2) + 16'sh0001;
	endproperty
	a_fwd_wrap: assert property (p_fwd_wrap) else $error("forward step wrong");
	property p_rev_wrap;
		!rev_fwd_in && !rev_rev_in ##1 !rev_fwd_in && rev_rev_in ##1
		!rev_fwd_in && !rev_rev_in |=>
		turns_out == $past(turns_out, 2) - 16'sh0001;
	endproperty
	a_rev_wrap: assert property (p_rev_wrap) else $error("reverse step wrong");
	property p_servo_gate;
		!xfer_done_out && !incremental_mode_out |-> !servo_on_out;
	endproperty
	a_servo_gate: assert property (p_servo_gate) else $error("servo on early");
	property p_bb_inv;
		baseblock_out == !servo_on_out;
	endproperty
	a_bb_inv: assert property (p_bb_inv) else $error("baseblock mismatch");
	property p_byte_hold;
		ser_valid_out && !ser_ready_in |=> ser_valid_out && $stable(ser_data_out);
	endproperty
	a_byte_hold: assert property (p_byte_hold) else $error("byte dropped");
	property p_incr_quiet;
		incremental_mode_out |-> !ser_valid_out && !battery_alarm_out && !setup_needed_out;
	endproperty
	a_incr_quiet: assert property (p_incr_quiet) else $error("incremental leak");
	property p_alarm_held;
		battery_alarm_out |=> battery_alarm_out;
	endproperty
	a_alarm_held: assert property (p_alarm_held) else $error("alarm cleared");
	property p_alarm_pu;
		$rose(battery_alarm_out) |-> since_rst_q <= 4'hc;
	endproperty
	a_alarm_pu: assert property (p_alarm_pu) else $error("late battery alarm");
	property p_mode_pu;
		$changed(incremental_mode_out) |-> since_rst_q <= 4'hc;
	endproperty
	a_mode_pu: assert property (p_mode_pu) else $error("mode changed live");
	property p_gray;
		!xfer_done_out && $changed({pulse_b_out, pulse_a_out}) |->
			$changed(pulse_a_out) != $changed(pulse_b_out);
	endproperty
	a_gray: assert property (p_gray) else $error("pulse not gray");

	c_wrap: cover property (turns_out == MT_MIN);
	c_done: cover property ($rose(xfer_done_out));
	c_stall: cover property (ser_valid_out && !ser_ready_in);
endmodule

bind abs_position_handshake abs_pos_checker #(
	.REQ_WAIT(REQ_WAIT),
	.SETTLE(SETTLE)
) u_chk (
	.mclk_in(mclk_in), .srst_in(srst_in), .rev_fwd_in(rev_fwd_in),
	.rev_rev_in(rev_rev_in), .ser_data_out(ser_data_out),
	.ser_valid_out(ser_valid_out), .ser_ready_in(ser_ready_in),
	.pulse_a_out(pulse_a_out), .pulse_b_out(pulse_b_out),
	.servo_on_out(servo_on_out), .baseblock_out(baseblock_out),
	.battery_alarm_out(battery_alarm_out), .setup_needed_out(setup_needed_out),
	.incremental_mode_out(incremental_mode_out),
	.xfer_done_out(xfer_done_out), .turns_out(turns_out)
);
`default_nettype wire

// ---- host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input wire logic  mclk_in,
	input wire logic  clr_in,
	input wire logic  slow_in,
	input wire logic  ser_valid_in,
	input wire logic  [7:0] ser_data_in,
	output var logic  ser_ready_out,
	output var logic  [63:0] frame_out,
	output var logic  [3:0] count_out
);
	// receiver ready after clear
	// a slow host accepts only every other cycle to stall the buffer
	always_ff @(posedge mclk_in)
		if (clr_in)
			ser_ready_out <= 1'b0;
		else
			ser_ready_out <= slow_in ? ~ser_ready_out : 1'b1;

	always_ff @(posedge mclk_in)
		if (clr_in)
		begin
			frame_out <= 64'h0;
			count_out <= 4'h0;
		end
		else if (ser_valid_in && ser_ready_out)
		begin
			frame_out <= {frame_out[55:0], ser_data_in};
			count_out <= count_out + 4'h1;
		end
endmodule
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
	import abs_pos_pkg::*;
	logic        mclk_in = 1'b0;
	logic        srst_in = 1'b1;
	logic        req = 1'b0, sel = 1'b0, batt = 1'b0, lost = 1'b0, son = 1'b1;
	logic        ea = 1'b0, eb = 1'b0, fwd = 1'b0, rev = 1'b0;
	logic        clr = 1'b1, slow = 1'b0;
	logic [15:0] preset = 16'h0, tpos = 16'h0;
	logic [7:0]  sdata;
	logic        svalid, sready, pa, pb, son_o, bb, alarm, setup, incr, done;
	logic [15:0] turns;
	logic [63:0] frame_q;
	logic [3:0]  cnt;
	int          miscompares = 0;
	int          n_tests = 0;

	always #2 mclk_in = ~mclk_in;

	abs_position_handshake #(.REQ_WAIT(20), .SETTLE(10)) dut (
		.mclk_in(mclk_in), .srst_in(srst_in), .absolute_data_request_in(req),
		.encoder_usage_select_in(sel), .battery_low_in(batt),
		.backup_lost_in(lost), .servo_on_req_in(son), .enc_a_in(ea),
		.enc_b_in(eb), .turns_preset_in(preset), .rev_fwd_in(fwd),
		.rev_rev_in(rev), .turn_pos_in(tpos), .ser_data_out(sdata),
		.ser_valid_out(svalid), .ser_ready_in(sready), .pulse_a_out(pa),
		.pulse_b_out(pb), .servo_on_out(son_o), .baseblock_out(bb),
		.battery_alarm_out(alarm), .setup_needed_out(setup),
		.incremental_mode_out(incr), .xfer_done_out(done), .turns_out(turns));
	host_model host (.mclk_in(mclk_in), .clr_in(clr), .slow_in(slow),
		.ser_valid_in(svalid), .ser_data_in(sdata), .ser_ready_out(sready),
		.frame_out(frame_q), .count_out(cnt));

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge mclk_in);
	endtask

	// request held low through power-up, first raise well after release
	task automatic power_up(input logic s, b, l, input logic [15:0] p);
		@(negedge mclk_in);
		srst_in = 1'b1;
		req = 1'b0;
		sel = s;
		batt = b;
		lost = l;
		preset = p;
		cyc(6);
		chk(64'({bb, son_o, svalid}), 64'h4);
		srst_in = 1'b0;
		cyc(14);
	endtask

	task automatic step(input logic f, r, input logic [15:0] exp);
		fwd = f;
		rev = r;
		cyc(1);
		fwd = 1'b0;
		rev = 1'b0;
		cyc(3);
		chk(64'(turns), 64'(exp));
	endtask

	// one full transfer; count moves during the wait to prove the snapshot
	task automatic xfer(input logic s, input logic [15:0] t, p, input logic [7:0] st);
		logic [7:0]  x;
		logic [15:0] rises;
		logic        prev;
		int          k;
		x = t[15:8] ^ t[7:0] ^ p[15:8] ^ p[7:0] ^ st;
		rises = 16'h0;
		slow = s;
		tpos = p;
		req = 1'b0;
		clr = 1'b1;
		cyc(4);
		clr = 1'b0;
		req = 1'b1;
		cyc(6);
		tpos = p + 16'h0011;
		step(1'b1, 1'b0, t + 16'h0001);
		prev = pa;
		k = 0;
		while (!(done === 1'b1 && cnt == 4'h8) && k < 800)
		begin
			chk(64'(son_o), 64'h0);
			if (pa === 1'b1 && prev === 1'b0)
				rises++;
			prev = pa;
			k++;
			cyc(1);
		end
		chk(64'(k < 800), 64'h1);
		chk(frame_q, {FRAME_SYNC, t, p, st, x, FRAME_END});
		chk(64'(rises), 64'(p));
		cyc(2);
		chk(64'({son_o, bb}), 64'h2);
		ea = 1'b1;
		eb = 1'b1;
		cyc(4);
		chk(64'({pa, pb}), 64'h3);
		ea = 1'b0;
		eb = 1'b0;
		cyc(4);
		$display("transfer test done");
	endtask

	task automatic t_count;
		power_up(USAGE_ABSOLUTE, 1'b1, 1'b0, 16'h7ffe);
		chk(64'({incr, alarm, setup, son_o}), 64'h4);
		step(1'b1, 1'b0, 16'h7fff);
		step(1'b1, 1'b0, 16'h8000);
		step(1'b0, 1'b1, 16'h7fff);
		step(1'b1, 1'b1, 16'h7fff);
		batt = 1'b0;
		cyc(3);
		chk(64'(alarm), 64'h1);
		xfer(1'b0, 16'h7fff, 16'h0003, 8'h01);
		xfer(1'b1, 16'h8000, 16'h0002, 8'h01);
		$display("count test done");
	endtask

	task automatic t_incr;
		logic seen;
		power_up(USAGE_INCREMENTAL, 1'b1, 1'b1, 16'h0005);
		chk(64'({incr, alarm, setup}), 64'h4);
		req = 1'b1;
		sel = USAGE_ABSOLUTE;
		seen = 1'b0;
		repeat (60)
		begin
			cyc(1);
			seen = seen | svalid;
		end
		chk(64'(seen), 64'h0);
		chk(64'({incr, son_o, bb}), 64'h6);
		$display("incremental test done");
	endtask

	task automatic t_lost;
		power_up(USAGE_ABSOLUTE, 1'b0, 1'b1, 16'h1234);
		chk(64'(turns), 64'h0);
		chk(64'({incr, alarm, setup}), 64'h1);
		batt = 1'b1;
		cyc(3);
		chk(64'(alarm), 64'h0);
		xfer(1'b0, 16'h0000, 16'h0000, 8'h02);
		$display("lost backup test done");
	endtask

	initial
	begin
		t_count;
		t_incr;
		t_lost;
		end_sim;
	end

	// watchdog: the tests need roughly 450 cycles
	initial
	begin
		#(4 * 6000);
		miscompares++;
		end_sim;
	end
endmodule
`default_nettype wire
